/* File: hw/swi_ctrl.v */
`timescale 1ns/1ps
`include "swi_regs.vh"
// What this block does
// - Sleep, port wake on, port irq off: change wakes, resume next instruction, clocks stopped
// - Sleep, both port enables, interrupts off: wake, next instruction, set port flag
// - Sleep, both port enables, interrupts on: wake, vector 0x06, set port flag
// - Port wake enable clear: port change in sleep never wakes
// - Sleep entry, conversion enables clear: clear running bit, stop converter, no wake
// - Sleep entry, only conversion irq on: set done flag, clear running, stop, no wake
// - Sleep with conversion wake on: oscillator and timers keep running
// - Conversion wake only, conversion irq off: wake on conversion completion, resume next instruction
// - Timer overflow never wakes from sleep; timer is stopped unless conversion wake is on
// - Normal, timer irq and interrupts on: set overflow flag, vector 0x09
// - Normal, timer irq on, interrupts off: set overflow flag, continue
// - Sleep, conversion enables and interrupts on: wake, set done, vector 0x0C
// - Sleep, conversion enables, interrupts off: wake, set done, next instruction
module swi_ctrl #(
    parameter PORT_W = 8
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_sys_rst,
    // Core control
    input wire i_sleep_enter,
    input wire i_enable_interrupts_instr,
    input wire i_disable_interrupts_instr,
    input wire i_vector_ack,
    // Enable registers as written by software
    input wire [7:0] i_wake_enable_control_reg,
    input wire [7:0] i_interrupt_enable_control_reg,
    // Flag clear strobes, one per flag
    input wire i_clr_port_change_pending_flag,
    input wire i_clr_conversion_done_flag,
    input wire i_clr_timer_overflow_flag,
    // Events
    input wire [PORT_W-1:0] i_port_pins,
    input wire i_conversion_done,
    input wire i_conversion_start,
    input wire i_main_timer_counter_ovf,
    // Outputs to core and peripherals
    output reg o_sleeping,
    output reg o_wake,
    output reg o_resume_next,
    output reg o_vector_req,
    output reg [7:0] o_vector_addr,
    output reg o_global_int_en,
    output reg o_port_change_pending_flag,
    output reg o_conversion_done_flag,
    output reg o_timer_overflow_flag,
    output reg o_conversion_running_bit,
    output wire o_osc_run,
    output wire o_timers_run
);
    localparam ST_RUN = 1'b0;
    localparam ST_SLEEP = 1'b1;

    wire [PORT_W-1:0] port_sync;
    reg [PORT_W-1:0] port_prev_ff;
    reg state_ff;
    reg nxt_state;
    reg keep_clk_ff;

    wire pc_we = i_wake_enable_control_reg[`SWI_PC_WAKE_BIT];
    wire ad_we = i_wake_enable_control_reg[`SWI_AD_WAKE_BIT];
    wire to_ie = i_interrupt_enable_control_reg[`SWI_TO_IE_BIT];
    wire pc_ie = i_interrupt_enable_control_reg[`SWI_PC_IE_BIT];
    wire ad_ie = i_interrupt_enable_control_reg[`SWI_AD_IE_BIT];
    wire port_chg = |(port_sync ^ port_prev_ff);
    wire in_sleep = (state_ff == ST_SLEEP);
    wire pc_wake = in_sleep & port_chg & pc_we;
    wire ad_wake = in_sleep & keep_clk_ff & i_conversion_done;
    wire any_wake = pc_wake | ad_wake;
    wire tmr_evt = ~in_sleep & i_main_timer_counter_ovf & to_ie;

    swi_sync #(
        .W(PORT_W)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_port_pins),
        .o_pin(port_sync)
    );

    // ==========================================
    // Clock gating requests
    assign o_osc_run = ~in_sleep | keep_clk_ff;
    assign o_timers_run = ~in_sleep | keep_clk_ff;

    // ==========================================
    // Sleep state machine
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (i_sleep_enter) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (any_wake) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_ff <= ST_RUN;
            keep_clk_ff <= 1'b0;
            port_prev_ff <= {PORT_W{1'b0}};
            o_sleeping <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            port_prev_ff <= port_sync;
            o_sleeping <= (nxt_state == ST_SLEEP);
            o_wake <= in_sleep & any_wake;
            if (~in_sleep & i_sleep_enter) begin
                keep_clk_ff <= ad_we;
            end else if (any_wake) begin
                keep_clk_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // Global interrupt state
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_global_int_en <= 1'b0;
        end else if (i_enable_interrupts_instr) begin
            o_global_int_en <= 1'b1;
        end else if (i_disable_interrupts_instr) begin
            o_global_int_en <= 1'b0;
        end
    end

    // ==========================================
    // Pending flags, a set beats a clear
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_port_change_pending_flag <= 1'b0;
            o_conversion_done_flag <= 1'b0;
            o_timer_overflow_flag <= 1'b0;
        end else begin
            if (pc_wake & pc_ie) begin
                o_port_change_pending_flag <= 1'b1;
            end else if (i_clr_port_change_pending_flag) begin
                o_port_change_pending_flag <= 1'b0;
            end
            if ((~in_sleep & i_sleep_enter & ~ad_we & ad_ie) | (ad_wake & ad_ie)) begin
                o_conversion_done_flag <= 1'b1;
            end else if (i_clr_conversion_done_flag) begin
                o_conversion_done_flag <= 1'b0;
            end
            if (tmr_evt) begin
                o_timer_overflow_flag <= 1'b1;
            end else if (i_clr_timer_overflow_flag) begin
                o_timer_overflow_flag <= 1'b0;
            end
        end
    end

    // ==========================================
    // Converter running bit
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_conversion_running_bit <= 1'b0;
        end else if (~in_sleep & i_sleep_enter & ~ad_we) begin
            o_conversion_running_bit <= 1'b0;
        end else if (i_conversion_done) begin
            o_conversion_running_bit <= 1'b0;
        end else if (i_conversion_start) begin
            o_conversion_running_bit <= 1'b1;
        end
    end

    // ==========================================
    // Resume or vector decision
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_resume_next <= 1'b0;
            o_vector_req <= 1'b0;
            o_vector_addr <= 8'h00;
        end else begin
            o_resume_next <= 1'b0;
            if (pc_wake) begin
                if (pc_ie & o_global_int_en) begin
                    o_vector_req <= 1'b1;
                    o_vector_addr <= `SWI_VEC_PORT;
                end else begin
                    o_resume_next <= 1'b1;
                end
            end else if (ad_wake) begin
                if (ad_ie & o_global_int_en) begin
                    o_vector_req <= 1'b1;
                    o_vector_addr <= `SWI_VEC_CONV;
                end else begin
                    o_resume_next <= 1'b1;
                end
            end else if (tmr_evt & o_global_int_en & ~o_vector_req) begin
                o_vector_req <= 1'b1;
                o_vector_addr <= `SWI_VEC_TIMER;
            end else if (i_vector_ack) begin
                o_vector_req <= 1'b0;
            end
        end
    end
endmodule

/* File: hw/swi_regs.vh */
`ifndef SWI_REGS_VH
`define SWI_REGS_VH
// ==========================================
// Bit positions in the control registers
`define SWI_PC_WAKE_BIT 0
`define SWI_AD_WAKE_BIT 2
`define SWI_TO_IE_BIT 0
`define SWI_PC_IE_BIT 1
`define SWI_AD_IE_BIT 3
// ==========================================
// Vectors
`define SWI_VEC_PORT 8'h06
`define SWI_VEC_TIMER 8'h09
`define SWI_VEC_CONV 8'h0c
// ==========================================
// Reset values
`define SWI_WAKE_RST 8'h00
`define SWI_IE_RST 8'h00
`endif

/* File: hw/swi_sync.v */
`timescale 1ns/1ps
module swi_sync #(
    parameter W = 8
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_sys_rst,
    // Pin data
    input wire [W-1:0] i_pin,
    output reg [W-1:0] o_pin
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    // ==========================================
    // Three stage synchroniser, change accepted when stages 2 and 3 agree
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            o_pin <= {W{1'b0}};
        end else begin
            s1_ff <= i_pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            o_pin <= (s2_ff & s3_ff) | (o_pin & (s2_ff | s3_ff));
        end
    end
endmodule

/* File: verification/swi_core_model.sv */
`timescale 1ns/1ps
// ==========================================
// Core: takes a vector two cycles after the request
module swi_core_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Vector handshake
    input wire logic i_vector_req,
    output logic o_vector_ack
);
    logic [1:0] cnt_ff;
    always @(posedge i_mclk) begin
        if (i_sys_rst || !i_vector_req || o_vector_ack) begin
            cnt_ff <= 2'h0;
            o_vector_ack <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            o_vector_ack <= (cnt_ff == 2'h1);
        end
    end
endmodule

/* File: verification/swi_ctrl_chk.sv */
`timescale 1ns/1ps
// ==========================================
// Checker
module swi_ctrl_chk (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Inputs watched
    input wire logic i_vector_ack,
    input wire logic i_clr_timer_overflow_flag,
    input wire logic i_main_timer_counter_ovf,
    // Outputs watched
    input wire logic o_sleeping,
    input wire logic o_wake,
    input wire logic o_resume_next,
    input wire logic o_vector_req,
    input wire logic [7:0] o_vector_addr,
    input wire logic o_global_int_en,
    input wire logic o_timer_overflow_flag,
    input wire logic o_osc_run,
    input wire logic o_timers_run
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    wake_pulse_a: assert property (o_wake |=> !o_wake) else $error("wake too long");
    wake_exit_a: assert property (o_wake |-> !o_sleeping) else $error("asleep at wake");
    nogie_next_a: assert property (o_wake && !o_global_int_en |-> o_resume_next)
        else $error("no resume");
    gie_vec_a: assert property (o_wake && !o_resume_next |-> o_vector_req &&
        (o_vector_addr == 8'h06 || o_vector_addr == 8'h0c)) else $error("bad vector");
    awake_run_a: assert property (!o_sleeping |-> o_osc_run && o_timers_run)
        else $error("clocks stopped");
    vec_hold_a: assert property (o_vector_req && !i_vector_ack |=>
        o_vector_req && $stable(o_vector_addr)) else $error("vector dropped");
    ovf_sleep_a: assert property (o_sleeping && i_main_timer_counter_ovf |=> !o_wake)
        else $error("overflow woke");
    tflag_keep_a: assert property (o_timer_overflow_flag && !i_clr_timer_overflow_flag
        |=> o_timer_overflow_flag) else $error("flag lost");
    cover property (o_wake && o_resume_next);
    cover property (o_vector_req && o_vector_addr == 8'h0c);
    cover property (o_sleeping && i_main_timer_counter_ovf);
endmodule
bind swi_ctrl swi_ctrl_chk u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_vector_ack(i_vector_ack), .i_clr_timer_overflow_flag(i_clr_timer_overflow_flag),
    .i_main_timer_counter_ovf(i_main_timer_counter_ovf), .o_sleeping(o_sleeping),
    .o_wake(o_wake), .o_resume_next(o_resume_next), .o_vector_req(o_vector_req),
    .o_vector_addr(o_vector_addr), .o_global_int_en(o_global_int_en),
    .o_timer_overflow_flag(o_timer_overflow_flag), .o_osc_run(o_osc_run),
    .o_timers_run(o_timers_run));

/* File: verification/swi_ctrl_tb.sv */
`timescale 1ns/1ps
// ==========================================
// Testbench
module swi_ctrl_tb;
    logic clk = 0, rst = 1, slp = 0, enable_interrupts_instr = 0, dsi = 0, cs = 0, cd = 0, ov = 0, cl = 0;
    logic [7:0] wk = 0, ie = 0, pins = 0, va;
    wire ack, slpg, wake, rn, vr, gie, fp, fc, ft, crun, osc, tmr;
    int n_mismatch = 0, compares = 0;
    always #5 clk = ~clk;
    swi_ctrl #(.PORT_W(8)) dut (.i_mclk(clk), .i_sys_rst(rst), .i_sleep_enter(slp),
        .i_enable_interrupts_instr(enable_interrupts_instr), .i_disable_interrupts_instr(dsi), .i_vector_ack(ack),
        .i_wake_enable_control_reg(wk), .i_interrupt_enable_control_reg(ie),
        .i_clr_port_change_pending_flag(cl), .i_clr_conversion_done_flag(cl),
        .i_clr_timer_overflow_flag(cl), .i_port_pins(pins), .i_conversion_done(cd),
        .i_conversion_start(cs), .i_main_timer_counter_ovf(ov), .o_sleeping(slpg),
        .o_wake(wake), .o_resume_next(rn), .o_vector_req(vr), .o_vector_addr(va),
        .o_global_int_en(gie), .o_port_change_pending_flag(fp), .o_conversion_done_flag(fc),
        .o_timer_overflow_flag(ft), .o_conversion_running_bit(crun), .o_osc_run(osc),
        .o_timers_run(tmr));
    swi_core_model core (.i_mclk(clk), .i_sys_rst(rst), .i_vector_req(vr), .o_vector_ack(ack));
    task conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One case: enables, global state, sleep, one event, then the outcome
    task run(input logic [7:0] w, i, input logic g, s, input logic [1:0] ev, input logic ew,
        input logic [7:0] vec, input logic [2:0] fl);
        logic sw, sr, sv;
        logic [7:0] sa;
        sw = 0; sr = 0; sv = 0; sa = 0;
        rst = 1; step(2); rst = 0; wk = w; ie = i; enable_interrupts_instr = 1; cs = 1;
        step(1); chk(gie, 1);
        chk(crun, 1);
        enable_interrupts_instr = 0; dsi = !g; cs = 0; slp = s;
        step(1); slp = 0; dsi = 0; chk(gie, g);
        step(1); chk(slpg, s);
        if (s) chk(crun, w[2]);
        if (s) chk({osc, tmr}, {2{w[2]}});
        pins = (ev == 0) ? 8'h5a : 8'h00; cd = (ev == 1); ov = (ev == 2);
        step(1); cd = 0; ov = 0;
        repeat (10) begin
            if (wake === 1'b1) begin sw = 1; sr = rn; end
            if (vr === 1'b1 && !sv) begin sv = 1; sa = va; end
            step(1);
        end
        chk(sw, ew);
        if (ew) chk(sr, vec == 0);
        chk(sv, vec != 0); chk(sa, vec); chk({fp, fc, ft}, fl);
        cl = 1; pins = 0; step(1); cl = 0; step(6); chk({fp, fc, ft}, 0);
        $display("test done wake %h irq %h", w, i);
    endtask
    initial begin
        step(8);
        run(8'h01, 8'h00, 0, 1, 0, 1, 8'h00, 3'h0);
        run(8'h01, 8'h02, 0, 1, 0, 1, 8'h00, 3'h4);
        run(8'h01, 8'h02, 1, 1, 0, 1, 8'h06, 3'h4);
        run(8'h00, 8'h00, 1, 1, 0, 0, 8'h00, 3'h0);
        run(8'h00, 8'h00, 0, 1, 1, 0, 8'h00, 3'h0);
        run(8'h00, 8'h08, 0, 1, 1, 0, 8'h00, 3'h2);
        run(8'h04, 8'h00, 0, 1, 1, 1, 8'h00, 3'h0);
        run(8'h04, 8'h08, 1, 1, 1, 1, 8'h0c, 3'h2);
        run(8'h04, 8'h08, 0, 1, 1, 1, 8'h00, 3'h2);
        run(8'h00, 8'h01, 1, 1, 2, 0, 8'h00, 3'h0);
        run(8'h00, 8'h01, 1, 0, 2, 0, 8'h09, 3'h1);
        run(8'h00, 8'h01, 0, 0, 2, 0, 8'h00, 3'h1);
        conclude();
    end
    initial begin
        repeat (12 * 40 + 8) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule
